// ==== rtl/cbl_pkg.sv ====
// Shared constants, types and decode helpers for the skip, branch and data move execution unit.
// Assumes a single core clock and a synchronous active-high reset in every user.
package cbl_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int NREGS = 32;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] FLAGS_OFF = 8'h04;
  localparam logic [7:0] PC_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam int STATUS_UNK_BIT = 0;
  localparam int STATUS_STATE_LSB = 4;

  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] REG_RST = 8'h00;

  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;

  localparam logic [3:0] PAIR_X = 4'hD;
  localparam logic [3:0] PAIR_Y = 4'hE;
  localparam logic [3:0] PAIR_Z = 4'hF;

  localparam logic [15:0] OP_SKIPR_MASK = 16'hFE08;
  localparam logic [15:0] OP_SKIPR_VAL = 16'hFE00;
  localparam logic [7:0] OP_SKIPIOC = 8'h99;
  localparam logic [7:0] OP_SKIPIOS = 8'h9B;
  localparam logic [7:0] OP_COPY_REG_PAIR = 8'h01;
  localparam logic [4:0] OP_BRANCH = 5'h1E;
  localparam logic [5:0] OP_MOV = 6'h0B;
  localparam logic [5:0] OP_IND = 6'h24;
  localparam logic [6:0] OP_JMP_HI = 7'h4A;
  localparam logic [3:0] OP_LDI = 4'hE;
  localparam logic [15:0] OP_DISP_MASK = 16'hD000;
  localparam logic [15:0] OP_DISP_VAL = 16'h8000;
  localparam logic [3:0] SUB_DIRECT = 4'h0;
  localparam logic [3:0] SUB_Z_INC = 4'h1;
  localparam logic [3:0] SUB_Z_DEC = 4'h2;
  localparam logic [3:0] SUB_Y_INC = 4'h9;
  localparam logic [3:0] SUB_Y_DEC = 4'hA;
  localparam logic [3:0] SUB_X = 4'hC;
  localparam logic [3:0] SUB_X_INC = 4'hD;
  localparam logic [3:0] SUB_X_DEC = 4'hE;

  typedef enum logic [3:0] {
    ST_EXEC = 4'h1,
    ST_MEM = 4'h2,
    ST_SKIP = 4'h4,
    ST_BUBBLE = 4'h8
  } cbl_state_e;

  typedef enum logic [1:0] {
    PM_PLAIN = 2'h0,
    PM_INC = 2'h1,
    PM_DEC = 2'h2
  } cbl_ptr_mode_e;

  // True for the opcodes that carry a second program word.
  function automatic logic cbl_two_word(input logic [15:0] ins);
    return ((ins[15:10] == OP_IND) && (ins[3:0] == SUB_DIRECT)) ||
           ((ins[15:9] == OP_JMP_HI) && (ins[3:2] == 2'h3));
  endfunction
endpackage

// ==== rtl/cbl_regfile.sv ====
// Thirty-two byte working registers with a byte write port and a pair write port.
// Assumes the caller never writes the same register through both ports in one cycle.
`timescale 1ns/1ps
module cbl_regfile (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] ra_i,
  input wire logic [4:0] rb_i,
  output logic [7:0] ra_data_o,
  output logic [7:0] rb_data_o,
  input wire logic [3:0] pair_sel_i,
  output logic [15:0] pair_data_o,
  input wire logic byte_we_i,
  input wire logic [4:0] byte_addr_i,
  input wire logic [7:0] byte_data_i,
  input wire logic word_we_i,
  input wire logic [3:0] word_pair_i,
  input wire logic [15:0] word_data_i
);
  logic [7:0] regs [cbl_pkg::NREGS];

  for (genvar gi = 0; gi < cbl_pkg::NREGS; gi++) begin : g_reg
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        regs[gi] <= cbl_pkg::REG_RST;
      end else if (word_we_i && (word_pair_i == 4'(gi / 2))) begin
        regs[gi] <= word_data_i[(gi % 2) * cbl_pkg::DATA_W +: cbl_pkg::DATA_W];
      end else if (byte_we_i && (byte_addr_i == 5'(gi))) begin
        regs[gi] <= byte_data_i;
      end
    end
  end

  assign ra_data_o = regs[ra_i];
  assign rb_data_o = regs[rb_i];
  assign pair_data_o = {regs[{pair_sel_i, 1'b1}], regs[{pair_sel_i, 1'b0}]};
endmodule

// ==== rtl/cbl_cond.sv ====
// Branch condition evaluator: picks one status flag and compares it with the wanted value.
// Purely combinational; the caller qualifies the result with its own decode.
`timescale 1ns/1ps
module cbl_cond (
  input wire logic [7:0] flags_i,
  input wire logic [2:0] sel_i,
  input wire logic want_set_i,
  output logic taken_o
);
  logic flag_bit;

  always_comb begin
    // Zero, carry, negative, half carry, transfer, overflow and interrupt flags are tested as stored.
    flag_bit = flags_i[sel_i];
    // The sign position is formed live from negative and overflow, so it cannot go stale.
    if (sel_i == cbl_pkg::FLAG_S) begin
      flag_bit = flags_i[cbl_pkg::FLAG_N] ^ flags_i[cbl_pkg::FLAG_V];
    end
  end

  assign taken_o = (flag_bit == want_set_i);
endmodule

// ==== rtl/cbl_exec.sv ====
// Execution unit for skips, conditional relative branches, moves and data loads and stores.
// Assumes program memory and data memory answer combinationally on the same clock.
// What this block does
// - Skip next when register bit is one.
// - Skip next when I/O bit is zero.
// - Skip next when I/O bit is one.
// - Branch tests chosen flag; taken takes two cycles.
// - Equal on zero set, not-equal on clear.
// - Carry set or lower; carry clear or higher.
// - Minus on negative set, plus on clear.
// - Signed compare uses negative xor overflow.
// - Half carry branches follow the half-carry flag.
// - Transfer branches follow the transfer flag.
// - Overflow branches follow the overflow flag.
// - Interrupt branches follow global interrupt enable.
// - Register, pair and constant moves: one cycle.
// - Indirect load two cycles, optional post-increment.
// - Pre-decrement load lowers pointer, then reads.
// - Offset load reads pointer plus q, unchanged.
// - Direct load reads address k, two cycles.
// - Indirect stores two cycles, increment or decrement.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module cbl_exec (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic [cbl_pkg::ADDR_W-1:0] pc_o,
  input wire logic [cbl_pkg::INSTR_W-1:0] instr_i,
  output logic [4:0] io_addr_o,
  input wire logic [cbl_pkg::DATA_W-1:0] io_data_i,
  output logic [cbl_pkg::ADDR_W-1:0] dmem_addr_o,
  output logic [cbl_pkg::DATA_W-1:0] dmem_wdata_o,
  output logic dmem_re_o,
  output logic dmem_we_o,
  input wire logic [cbl_pkg::DATA_W-1:0] dmem_rdata_i,
  input wire logic [cbl_pkg::APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [cbl_pkg::APB_DW-1:0] pwdata_i,
  output logic [cbl_pkg::APB_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  cbl_pkg::cbl_state_e state;
  cbl_pkg::cbl_state_e next_state;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic run;
  logic unknown_seen;
  logic [7:0] flags;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [4:0] mem_reg;
  logic mem_load;
  logic mem_direct;

  logic [4:0] f_rd;
  logic [4:0] f_rr;
  logic [2:0] f_bit;
  logic [15:0] f_k;
  logic [15:0] f_q;
  logic [3:0] f_sub;
  assign f_rd = instr_i[8:4];
  assign f_rr = {instr_i[9], instr_i[3:0]};
  assign f_bit = instr_i[2:0];
  // The seven-bit word offset is sign extended so backward branches wrap correctly.
  assign f_k = {{9{instr_i[9]}}, instr_i[9:3]};
  assign f_q = {10'h000, instr_i[13], instr_i[11:10], instr_i[2:0]};
  assign f_sub = instr_i[3:0];

  logic is_skip_reg;
  logic is_skip_ioc;
  logic is_skip_ios;
  logic is_branch;
  logic is_mov;
  logic is_copy_reg_pair;
  logic is_ldi;
  logic is_disp;
  logic is_ind;
  logic is_direct;
  logic exec_go;
  assign is_skip_reg = (instr_i & cbl_pkg::OP_SKIPR_MASK) == cbl_pkg::OP_SKIPR_VAL;
  assign is_skip_ioc = instr_i[15:8] == cbl_pkg::OP_SKIPIOC;
  assign is_skip_ios = instr_i[15:8] == cbl_pkg::OP_SKIPIOS;
  assign is_branch = instr_i[15:11] == cbl_pkg::OP_BRANCH;
  assign is_mov = instr_i[15:10] == cbl_pkg::OP_MOV;
  assign is_copy_reg_pair = instr_i[15:8] == cbl_pkg::OP_COPY_REG_PAIR;
  assign is_ldi = instr_i[15:12] == cbl_pkg::OP_LDI;
  assign is_disp = (instr_i & cbl_pkg::OP_DISP_MASK) == cbl_pkg::OP_DISP_VAL;
  assign is_ind = instr_i[15:10] == cbl_pkg::OP_IND;
  assign is_direct = is_ind && cbl_pkg::cbl_two_word(instr_i);
  assign exec_go = (state == cbl_pkg::ST_EXEC) && run;

  logic ptr_ok;
  logic [3:0] ptr_pair;
  cbl_pkg::cbl_ptr_mode_e ptr_mode;
  always_comb begin
    ptr_ok = 1'b1;
    ptr_pair = cbl_pkg::PAIR_Z;
    ptr_mode = cbl_pkg::PM_PLAIN;
    if (is_disp) begin
      ptr_pair = instr_i[3] ? cbl_pkg::PAIR_Y : cbl_pkg::PAIR_Z;
    end else begin
      case (f_sub)
        cbl_pkg::SUB_Z_INC: ptr_mode = cbl_pkg::PM_INC;
        cbl_pkg::SUB_Z_DEC: ptr_mode = cbl_pkg::PM_DEC;
        cbl_pkg::SUB_Y_INC: begin
          ptr_pair = cbl_pkg::PAIR_Y;
          ptr_mode = cbl_pkg::PM_INC;
        end
        cbl_pkg::SUB_Y_DEC: begin
          ptr_pair = cbl_pkg::PAIR_Y;
          ptr_mode = cbl_pkg::PM_DEC;
        end
        cbl_pkg::SUB_X: ptr_pair = cbl_pkg::PAIR_X;
        cbl_pkg::SUB_X_INC: begin
          ptr_pair = cbl_pkg::PAIR_X;
          ptr_mode = cbl_pkg::PM_INC;
        end
        cbl_pkg::SUB_X_DEC: begin
          ptr_pair = cbl_pkg::PAIR_X;
          ptr_mode = cbl_pkg::PM_DEC;
        end
        default: ptr_ok = 1'b0;
      endcase
    end
  end

  logic is_mem_ptr;
  logic known;
  assign is_mem_ptr = is_disp || (is_ind && ptr_ok);
  assign known = is_skip_reg || is_skip_ioc || is_skip_ios || is_branch || is_mov || is_copy_reg_pair ||
                 is_ldi || is_mem_ptr || is_direct;

  logic [4:0] ra_sel;
  logic [7:0] ra_data;
  logic [7:0] rb_data;
  logic [15:0] pair_data;
  logic byte_we;
  logic [4:0] byte_addr;
  logic [7:0] byte_data;
  logic word_we;
  logic [3:0] word_pair;
  logic [15:0] word_data;
  assign ra_sel = is_copy_reg_pair ? {instr_i[3:0], 1'b0} : (is_mov ? f_rr : f_rd);

  cbl_regfile u_regs (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .ra_i(ra_sel),
    .rb_i({instr_i[3:0], 1'b1}),
    .ra_data_o(ra_data),
    .rb_data_o(rb_data),
    .pair_sel_i(ptr_pair),
    .pair_data_o(pair_data),
    .byte_we_i(byte_we),
    .byte_addr_i(byte_addr),
    .byte_data_i(byte_data),
    .word_we_i(word_we),
    .word_pair_i(word_pair),
    .word_data_i(word_data)
  );

  logic br_taken;
  cbl_cond u_cond (
    .flags_i(flags),
    .sel_i(f_bit),
    .want_set_i(~instr_i[10]),
    .taken_o(br_taken)
  );

  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] ind_addr;
  logic io_bit;
  logic skip_hit;
  assign ptr_dec = pair_data - 16'h0001;
  assign ptr_inc = pair_data + 16'h0001;
  // The displaced form reads an address only; the pointer itself is never written back.
  assign ind_addr = is_disp ? (pair_data + f_q) : ((ptr_mode == cbl_pkg::PM_DEC) ? ptr_dec : pair_data);
  assign io_addr_o = instr_i[7:3];
  assign io_bit = io_data_i[f_bit];
  always_comb begin
    skip_hit = 1'b0;
    if (is_skip_reg) begin
      skip_hit = ra_data[f_bit];
    end else if (is_skip_ioc) begin
      skip_hit = ~io_bit;
    end else if (is_skip_ios) begin
      skip_hit = io_bit;
    end
  end

  always_comb begin
    byte_we = 1'b0;
    byte_addr = f_rd;
    byte_data = ra_data;
    word_we = 1'b0;
    word_pair = ptr_pair;
    word_data = ptr_inc;
    if (state == cbl_pkg::ST_MEM) begin
      byte_we = mem_load;
      byte_addr = mem_reg;
      byte_data = dmem_rdata_i;
    end else if (exec_go) begin
      if (is_mov) begin
        byte_we = 1'b1;
      end else if (is_ldi) begin
        byte_we = 1'b1;
        byte_addr = {1'b1, instr_i[7:4]};
        byte_data = {instr_i[11:8], instr_i[3:0]};
      end else if (is_copy_reg_pair) begin
        word_we = 1'b1;
        word_pair = instr_i[7:4];
        word_data = {rb_data, ra_data};
      end else if (is_ind && ptr_ok && (ptr_mode != cbl_pkg::PM_PLAIN)) begin
        // The access uses the latched address, so writing the pointer now is safe for both forms.
        word_we = 1'b1;
        word_data = (ptr_mode == cbl_pkg::PM_DEC) ? ptr_dec : ptr_inc;
      end
    end
  end

  always_comb begin
    next_state = state;
    next_pc = pc;
    case (state)
      cbl_pkg::ST_EXEC: begin
        if (run) begin
          next_pc = pc + 16'h0001;
          if (skip_hit) begin
            next_state = cbl_pkg::ST_SKIP;
          end else if (is_branch && br_taken) begin
            next_pc = pc + f_k + 16'h0001;
            next_state = cbl_pkg::ST_BUBBLE;
          end else if (is_mem_ptr) begin
            next_pc = pc;
            next_state = cbl_pkg::ST_MEM;
          end else if (is_direct) begin
            next_state = cbl_pkg::ST_MEM;
          end
        end
      end
      cbl_pkg::ST_SKIP: begin
        if (cbl_pkg::cbl_two_word(instr_i)) begin
          next_pc = pc + 16'h0002;
          next_state = cbl_pkg::ST_BUBBLE;
        end else begin
          next_pc = pc + 16'h0001;
          next_state = cbl_pkg::ST_EXEC;
        end
      end
      cbl_pkg::ST_MEM: begin
        next_pc = pc + 16'h0001;
        next_state = cbl_pkg::ST_EXEC;
      end
      cbl_pkg::ST_BUBBLE: next_state = cbl_pkg::ST_EXEC;
      default: next_state = cbl_pkg::ST_EXEC;
    endcase
  end

  logic apb_wr;
  logic apb_setup;
  logic addr_ok;
  logic pc_wr;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_setup = psel_i && !penable_i;
  assign addr_ok = (paddr_i == cbl_pkg::CTRL_OFF) || (paddr_i == cbl_pkg::FLAGS_OFF) ||
                   (paddr_i == cbl_pkg::PC_OFF) || (paddr_i == cbl_pkg::STATUS_OFF);
  // Loading the counter while running would race the sequencer, so it only lands while halted.
  assign pc_wr = apb_wr && (paddr_i == cbl_pkg::PC_OFF) && !run && (state == cbl_pkg::ST_EXEC);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= cbl_pkg::ST_EXEC;
      pc <= cbl_pkg::PC_RST;
    end else if (pc_wr) begin
      pc <= pwdata_i[15:0];
    end else begin
      state <= next_state;
      pc <= next_pc;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mem_addr <= cbl_pkg::PC_RST;
      mem_wdata <= cbl_pkg::REG_RST;
      mem_reg <= 5'h00;
      mem_load <= 1'b0;
      mem_direct <= 1'b0;
    end else if (exec_go) begin
      mem_addr <= ind_addr;
      mem_wdata <= ra_data;
      mem_reg <= f_rd;
      mem_load <= ~instr_i[9];
      mem_direct <= is_direct;
    end
  end

  assign pc_o = pc;
  assign dmem_addr_o = mem_direct ? instr_i : mem_addr;
  assign dmem_wdata_o = mem_wdata;
  assign dmem_re_o = (state == cbl_pkg::ST_MEM) && mem_load;
  assign dmem_we_o = (state == cbl_pkg::ST_MEM) && !mem_load;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run <= cbl_pkg::CTRL_RUN_RST;
    end else if (apb_wr && (paddr_i == cbl_pkg::CTRL_OFF)) begin
      run <= pwdata_i[cbl_pkg::CTRL_RUN_BIT];
    end
  end

  // Only software changes the flags; no instruction of this unit writes them.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flags <= cbl_pkg::FLAGS_RST;
    end else if (apb_wr && (paddr_i == cbl_pkg::FLAGS_OFF)) begin
      flags <= pwdata_i[7:0];
    end
  end

  // A new unknown opcode in the clearing cycle keeps the flag set.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      unknown_seen <= 1'b0;
    end else if (exec_go && !known) begin
      unknown_seen <= 1'b1;
    end else if (apb_wr && (paddr_i == cbl_pkg::STATUS_OFF) && pwdata_i[cbl_pkg::STATUS_UNK_BIT]) begin
      unknown_seen <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup && !pwrite_i) begin
      case (paddr_i)
        cbl_pkg::CTRL_OFF: prdata_o <= 32'(run);
        cbl_pkg::FLAGS_OFF: prdata_o <= 32'(flags);
        cbl_pkg::PC_OFF: prdata_o <= 32'(pc);
        cbl_pkg::STATUS_OFF: prdata_o <= 32'({state, 3'h0, unknown_seen});
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_skip_reg_bit: assert property (exec_go && is_skip_reg && ra_data[f_bit] |=>
    state == cbl_pkg::ST_SKIP && pc == $past(pc) + 16'h0001) else $error("register bit skip missed");
  a_skip_two_word: assert property (state == cbl_pkg::ST_SKIP && cbl_pkg::cbl_two_word(instr_i) |=>
    state == cbl_pkg::ST_BUBBLE && pc == $past(pc) + 16'h0002 ##1 state == cbl_pkg::ST_EXEC)
    else $error("two word skip length wrong");
  a_skip_io_clear: assert property (exec_go && is_skip_ioc && !io_bit |=> state == cbl_pkg::ST_SKIP)
    else $error("io clear skip missed");
  a_skip_io_set: assert property (exec_go && is_skip_ios |=> (state == cbl_pkg::ST_SKIP) == $past(io_bit))
    else $error("io set skip wrong");
  a_branch_target: assert property (exec_go && is_branch && br_taken |=>
    pc == $past(pc) + $past(f_k) + 16'h0001 ##1 state == cbl_pkg::ST_EXEC) else $error("bad branch target");
  a_branch_fall: assert property (exec_go && is_branch && !br_taken |=>
    state == cbl_pkg::ST_EXEC && pc == $past(pc) + 16'h0001) else $error("untaken branch not one cycle");
  a_branch_equal: assert property (exec_go && is_branch && f_bit == cbl_pkg::FLAG_Z |->
    br_taken == (flags[cbl_pkg::FLAG_Z] == !instr_i[10])) else $error("zero branch wrong");
  a_branch_carry: assert property (exec_go && is_branch && f_bit == cbl_pkg::FLAG_C |->
    br_taken == (flags[cbl_pkg::FLAG_C] == !instr_i[10])) else $error("carry branch wrong");
  a_branch_minus: assert property (exec_go && is_branch && f_bit == cbl_pkg::FLAG_N |->
    br_taken == (flags[cbl_pkg::FLAG_N] == !instr_i[10])) else $error("negative branch wrong");
  a_branch_signed: assert property (exec_go && is_branch && f_bit == cbl_pkg::FLAG_S |->
    br_taken == ((flags[cbl_pkg::FLAG_N] ^ flags[cbl_pkg::FLAG_V]) == !instr_i[10])) else $error("signed branch wrong");
  a_move_single: assert property (exec_go && (is_mov || is_ldi || is_copy_reg_pair) |=>
    state == cbl_pkg::ST_EXEC && pc == $past(pc) + 16'h0001) else $error("move not one cycle");
  a_load_two_cycle: assert property (exec_go && (is_mem_ptr || is_direct) |=>
    state == cbl_pkg::ST_MEM ##1 state == cbl_pkg::ST_EXEC) else $error("data access not two cycles");
  a_predec_addr: assert property (exec_go && is_ind && ptr_ok && ptr_mode == cbl_pkg::PM_DEC |=>
    dmem_addr_o == $past(pair_data) - 16'h0001) else $error("pre decrement address wrong");
  a_disp_addr: assert property (exec_go && is_disp |=>
    dmem_addr_o == $past(pair_data) + $past(f_q)) else $error("displacement address wrong");
  a_store_write: assert property (exec_go && is_mem_ptr && instr_i[9] |=>
    dmem_we_o && !dmem_re_o && dmem_wdata_o == $past(ra_data)) else $error("store not issued");
  a_flags_kept: assert property (!(apb_wr && paddr_i == cbl_pkg::FLAGS_OFF) |=> flags == $past(flags))
    else $error("flags changed by execution");

  c_skip_two_word: cover property (state == cbl_pkg::ST_SKIP && cbl_pkg::cbl_two_word(instr_i));
  c_branch_taken: cover property (exec_go && is_branch && br_taken);
  c_load_postinc: cover property (exec_go && is_ind && ptr_mode == cbl_pkg::PM_INC && !instr_i[9]);
  c_store_direct: cover property (state == cbl_pkg::ST_MEM && mem_direct && !mem_load);
endmodule

// ==== bench/cbl_mem_model.sv ====
// Program memory, data memory and low I/O space facing the execution unit.
// Assumes combinational reads and writes that land at the rising clock edge.
`timescale 1ns/1ps
module cbl_mem_model (
  input wire logic core_clk_i,
  input wire logic [15:0] pc_i,
  output logic [15:0] instr_o,
  input wire logic [4:0] io_addr_i,
  output logic [7:0] io_data_o,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic re_i,
  input wire logic we_i,
  output logic [7:0] rdata_o
);
  logic [15:0] rom [64];
  logic [7:0] ram [256];
  logic [7:0] io [32];
  logic [7:0] last = 8'h00;
  // An idle read port shows the inverse of its last byte, so a late sample cannot pass by luck.
  assign rdata_o = re_i ? ram[addr_i[7:0]] : ~last;
  assign instr_o = rom[pc_i[5:0]];
  assign io_data_o = io[io_addr_i];
  always @(posedge core_clk_i) begin
    if (re_i)
      last <= ram[addr_i[7:0]];
    if (we_i)
      ram[addr_i[7:0]] <= wdata_i;
  end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench: each instruction is run alone from a fixed address under APB control.
// Assumes the memory model answers combinationally and APB has no wait states.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] BASE = 16'h0010;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, re, we;
  logic [15:0] pc, instr, daddr;
  logic [4:0] ioa;
  logic [7:0] iod, wd, rd;
  int errors = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  cbl_exec i_dut (.core_clk_i(clk), .rst_i(rst), .pc_o(pc), .instr_i(instr), .io_addr_o(ioa), .io_data_i(iod),
    .dmem_addr_o(daddr), .dmem_wdata_o(wd), .dmem_re_o(re), .dmem_we_o(we), .dmem_rdata_i(rd), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));
  cbl_mem_model i_mem (.core_clk_i(clk), .pc_i(pc), .instr_o(instr), .io_addr_i(ioa), .io_data_o(iod),
    .addr_i(daddr), .wdata_i(wd), .re_i(re), .we_i(we), .rdata_o(rd));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      print_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // Runs one instruction; nxt is its successor's offset from BASE, and the undecoded filler word there must follow in one cycle.
  task automatic exe(input logic [15:0] ins, input logic [15:0] w2, input logic [7:0] fl, input int nxt,
    input int cyc);
    logic [31:0] q;
    logic e;
    int n;
    wr(cbl_pkg::CTRL_OFF, 32'h0000_0000);
    wr(cbl_pkg::PC_OFF, {16'h0000, BASE});
    wr(cbl_pkg::FLAGS_OFF, {24'h00_0000, fl});
    for (int i = 0; i < 64; i++)
      i_mem.rom[i] = 16'hFFFF;
    i_mem.rom[BASE[5:0]] = ins;
    i_mem.rom[BASE[5:0] + 6'h01] = w2;
    wr(cbl_pkg::CTRL_OFF, 32'h0000_0001);
    n = 0;
    while (pc !== BASE + nxt[15:0] + 16'h0001 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("cycles", cyc + 1, n);
    if (n == 12)
      print_verdict();
    wr(cbl_pkg::CTRL_OFF, 32'h0000_0000);
    apb(1'b0, cbl_pkg::FLAGS_OFF, 32'h0000_0000, q, e);
    chk("flags", {24'h00_0000, fl}, q);
  endtask
  function automatic logic [15:0] load_constant(input int d, input logic [7:0] k);
    return {4'hE, k[7:4], d[3:0], k[3:0]};
  endfunction
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    apb(1'b0, cbl_pkg::PC_OFF, 32'h0000_0000, q, e);
    chk("pc reset", {16'h0000, cbl_pkg::PC_RST}, q);
    apb(1'b0, cbl_pkg::FLAGS_OFF, 32'h0000_0000, q, e);
    chk("flags reset", {24'h00_0000, cbl_pkg::FLAGS_RST}, q);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    $display("test reset done");
  endtask
  task automatic t_branch();
    int k;
    logic [7:0] fl;
    for (int s = 0; s < 8; s++) begin
      for (int m = 0; m < 4; m++) begin
        k = s[0] ? 5 : -3;
        fl = (s == 4) ? (m[0] ? 8'h08 : 8'h0C) : 8'(m[0]) << s;
        if (m[0] == m[1])
          exe({5'h1E, ~m[1], k[6:0], s[2:0]}, 16'hFFFF, fl, k + 1, 2);
        else
          exe({5'h1E, ~m[1], k[6:0], s[2:0]}, 16'hFFFF, fl, 1, 1);
      end
    end
    $display("test branch done");
  endtask
  task automatic t_skip();
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 32; i++)
      i_mem.io[i] = 8'h00;
    i_mem.io[5] = 8'h02;
    exe(load_constant(16, 8'hA5), 16'hFFFF, 8'h00, 1, 1);
    exe(16'hFF00, 16'hFFFF, 8'h00, 2, 2);
    exe(16'hFF01, 16'hFFFF, 8'h00, 1, 1);
    exe(16'hFF02, 16'h9130, 8'h00, 3, 3);
    exe(16'h9928, 16'hFFFF, 8'h00, 2, 2);
    exe(16'h9929, 16'hFFFF, 8'h00, 1, 1);
    exe(16'h9B29, 16'h9130, 8'h00, 3, 3);
    exe(16'h9B28, 16'hFFFF, 8'h00, 1, 1);
    // Every filler word is an undecoded opcode, so the sticky flag stays up until software clears it.
    apb(1'b0, cbl_pkg::STATUS_OFF, 32'h0000_0000, q, e);
    chk("status sticky", (32'h1 << cbl_pkg::STATUS_STATE_LSB) | (32'h1 << cbl_pkg::STATUS_UNK_BIT), q);
    wr(cbl_pkg::STATUS_OFF, 32'h0000_0001);
    apb(1'b0, cbl_pkg::STATUS_OFF, 32'h0000_0000, q, e);
    chk("status cleared", 32'h1 << cbl_pkg::STATUS_STATE_LSB, q);
    $display("test skip done");
  endtask
  task automatic t_data();
    int rr[6] = '{17, 18, 19, 20, 22, 23};
    logic [7:0] ev[6] = '{8'h3C, 8'hC3, 8'h77, 8'h77, 8'hC3, 8'h77};
    i_mem.ram[8'h40] = 8'h5A;
    i_mem.ram[8'h7F] = 8'h3C;
    i_mem.ram[8'h81] = 8'hC3;
    i_mem.ram[8'h90] = 8'h77;
    exe(load_constant(26, 8'h40), 16'hFFFF, 8'h81, 1, 1);
    exe(load_constant(27, 8'h00), 16'hFFFF, 8'h00, 1, 1);
    exe(load_constant(28, 8'h81), 16'hFFFF, 8'h00, 1, 1);
    exe(load_constant(29, 8'h00), 16'hFFFF, 8'h00, 1, 1);
    exe(16'h910D, 16'hFFFF, 8'h00, 1, 2);
    exe(16'h930A, 16'hFFFF, 8'h00, 1, 2);
    exe(16'h911A, 16'hFFFF, 8'h00, 1, 2);
    exe(16'h812A, 16'hFFFF, 8'h00, 1, 2);
    exe(16'h9130, 16'h0090, 8'h00, 2, 2);
    exe(16'h2F43, 16'hFFFF, 8'h00, 1, 1);
    exe(16'h01B9, 16'hFFFF, 8'h00, 1, 1);
    for (int i = 0; i < 6; i++)
      exe(16'h920D | 16'(rr[i] << 4), 16'hFFFF, 8'h00, 1, 2);
    exe(16'h930A, 16'hFFFF, 8'h00, 1, 2);
    exe(16'h9300, 16'h0050, 8'h00, 2, 2);
    chk("ram 50", 32'h0000_005A, {24'h0, i_mem.ram[8'h50]});
    chk("ram 80", 32'h0000_005A, {24'h0, i_mem.ram[8'h80]});
    chk("ram 7e", 32'h0000_005A, {24'h0, i_mem.ram[8'h7E]});
    for (int i = 0; i < 6; i++)
      chk("ram x", {24'h0, ev[i]}, {24'h0, i_mem.ram[8'h41 + i]});
    $display("test data done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_branch();
    t_skip();
    t_data();
    print_verdict();
  end
endmodule
